//--- src/ivpr_top.sv
// interrupt vector priority resolver with its AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - each source has unique vector and address
// - table address is four times vector
// - ten registers hold 4-bit levels 0..15
// - shared field: smaller vector ranks higher
// - power-on reset clears every level
// - equal levels resolved by fixed order
// - pins use vectors 64..71, fields in order
// - fixed sources 11,12,14; reserved never issued
// - level 0 masked; non-maskable at 16
// - field value is the level directly
// - accept only above the core mask
module ivpr_top
    import ivpr_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic      [31:0]         hrdata,
    input  wire logic [NPIN-1:0]     ext_request_pin,
    input  wire logic                nmi_pin,
    input  wire logic                break_req,
    input  wire logic                debug_interface_request,
    input  wire logic [NPER-1:0]     periph_req,
    input  wire logic [3:0]          core_interrupt_mask,
    input  wire logic                core_take,
    output logic                     core_int_req,
    output logic      [7:0]          core_vec_num,
    output logic      [31:0]         core_vec_addr,
    output logic      [4:0]          core_level,
    output logic                     irq
);
    // ========================================================================
    // declarations
    // ========================================================================
    logic [NSYN-1:0]     sync1_r;         // first stage, read only by stage 2
    logic [NSYN-1:0]     sync2_r;         // usable pin levels
    logic                nmi_d_r;         // previous synced nmi level
    logic                nmi_edge;        // rising edge of nmi pin
    logic                nmi_pend_r;      // held nmi request
    logic                brk_pend_r;      // held break request
    logic                dbg_pend_r;      // held debug request
    logic                take_ok;         // core took the presented vector
    logic [NFLD*4-1:0]   prio_flat;       // all priority fields
    logic                win_found;
    logic [7:0]          win_vec;
    logic [4:0]          win_lvl;
    logic                acc;             // winner beats the core mask
    logic                ap_ok;           // address phase taken
    logic [7:0]          ap_ofs;          // low address bits of the phase
    logic                ap_wr_r;         // write data phase pending
    logic [7:0]          ap_ofs_r;        // its offset
    logic                prio_we;         // priority register write now
    logic                rd_stat;         // status read, clears it
    logic [ST_W-1:0]     status_r;
    logic [ST_W-1:0]     status_set;
    logic [ST_W-1:0]     imask_r;
    logic [31:0]         rd_word;         // addressed read value
    logic                hreadyout_r;
    logic                hresp_r;
    logic [31:0]         hrdata_r;
    logic                core_int_req_r;
    logic [7:0]          core_vec_num_r;
    logic [31:0]         core_vec_addr_r;
    logic [4:0]          core_level_r;
    logic                irq_r;
    logic [NFLD*4-1:0]   prio_q_r;        // helper: fields one cycle back

    assign hreadyout     = hreadyout_r;
    assign hresp         = hresp_r;
    assign hrdata        = hrdata_r;
    assign core_int_req  = core_int_req_r;
    assign core_vec_num  = core_vec_num_r;
    assign core_vec_addr = core_vec_addr_r;
    assign core_level    = core_level_r;
    assign irq           = irq_r;

    // ========================================================================
    // pin synchronisers: request pins and the non-maskable pin
    // ========================================================================
    for (genvar i = 0; i < NSYN; i++) begin : g_sync
        // two flops per pin, only the second stage reads the first
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sync1_r[i] <= 1'b0;
                sync2_r[i] <= 1'b0;
            end else begin
                sync1_r[i] <= (i == NPIN) ? nmi_pin : ext_request_pin[i % NPIN];
                sync2_r[i] <= sync1_r[i];
            end
        end
    end

    // edge detect on the synced nmi level only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_d_r <= 1'b0;
        end else begin
            nmi_d_r <= sync2_r[NPIN];
        end
    end
    assign nmi_edge = sync2_r[NPIN] & ~nmi_d_r;

    // ========================================================================
    // held requests for edge sources, kept until the core takes them
    // ========================================================================
    assign take_ok = core_take & core_int_req_r;

    // a new edge in the cycle of the take wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_pend_r <= 1'b0;
            brk_pend_r <= 1'b0;
            dbg_pend_r <= 1'b0;
        end else begin
            nmi_pend_r <= (nmi_pend_r & ~(take_ok && core_vec_num_r == VEC_NMI))
                          | nmi_edge;
            brk_pend_r <= (brk_pend_r & ~(take_ok && core_vec_num_r == VEC_BRK))
                          | break_req;
            dbg_pend_r <= (dbg_pend_r & ~(take_ok && core_vec_num_r == VEC_DBG))
                          | debug_interface_request;
        end
    end

    // ========================================================================
    // priority storage and arbitration
    // ========================================================================
    ivpr_prio_regs u_regs (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .wr_en     (prio_we),
        .wr_idx    (ap_ofs_r[5:2]),
        .wr_data   (hwdata[15:0]),
        .prio_flat (prio_flat)
    );

    // pins come first in the programmable order, vectors 64 upward
    ivpr_arbiter u_arb (
        .nmi_req   (nmi_pend_r),
        .brk_req   (brk_pend_r),
        .dbg_req   (dbg_pend_r),
        .prg_req   ({periph_req, sync2_r[NPIN-1:0]}),
        .prio_flat (prio_flat),
        .win_found (win_found),
        .win_vec   (win_vec),
        .win_lvl   (win_lvl)
    );

    // strictly above the mask; level 0 never gets here
    assign acc = win_found && (win_lvl > {1'b0, core_interrupt_mask});

    // ========================================================================
    // core side: request level, vector, table address and level
    // ========================================================================
    // outputs follow the live winner; the vector holds once the request drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_int_req_r  <= 1'b0;
            core_vec_num_r  <= 8'h00;
            core_vec_addr_r <= 32'h0000_0000;
            core_level_r    <= 5'h00;
        end else begin
            core_int_req_r <= acc;
            if (acc) begin
                core_vec_num_r  <= win_vec;
                core_level_r    <= win_lvl;
                core_vec_addr_r <= {22'h00_0000, win_vec, 2'b00};
            end
        end
    end

    // ========================================================================
    // AHB-Lite slave: zero wait, always OKAY
    // ========================================================================
    assign ap_ok  = hsel && hready && htrans[1];
    assign ap_ofs = haddr[7:0];

    // address phase capture for the following write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r  <= 1'b0;
            ap_ofs_r <= 8'h00;
        end else if (hready) begin
            ap_wr_r  <= ap_ok && hwrite;
            ap_ofs_r <= ap_ofs;
        end
    end

    // priority words take the low half; upper bits are dropped
    assign prio_we = ap_wr_r && ap_ofs_r <= OFS_PRIO9 && ap_ofs_r[1:0] == 2'b00;

    // bus handshake flops, fixed after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b0;
            hresp_r     <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end
    end

    // read mux; a write still in its data phase is forwarded so a
    // back-to-back read of the same word sees the new value
    always_comb begin
        logic [3:0] k;
        k       = ap_ofs[5:2];
        rd_word = 32'h0000_0000;
        if (ap_ofs[1:0] == 2'b00 && ap_ofs <= OFS_PRIO9) begin
            rd_word[15:0] = {prio_flat[(4*k)*4 +: 4], prio_flat[(4*k+1)*4 +: 4],
                             prio_flat[(4*k+2)*4 +: 4], prio_flat[(4*k+3)*4 +: 4]};
            if (ap_wr_r && ap_ofs_r == ap_ofs) begin
                rd_word[15:0] = hwdata[15:0];
            end
        end else if (ap_ofs == OFS_STATUS) begin
            rd_word[ST_W-1:0] = status_r;
        end else if (ap_ofs == OFS_IMASK) begin
            rd_word[ST_W-1:0] = (ap_wr_r && ap_ofs_r == OFS_IMASK) ?
                                hwdata[ST_W-1:0] : imask_r;
        end else if (ap_ofs == OFS_CUR) begin
            rd_word[CUR_VEC_LSB +: 8] = core_vec_num_r;
            rd_word[CUR_LVL_LSB +: 5] = core_level_r;
            rd_word[CUR_REQ_BIT]      = core_int_req_r;
        end
    end

    // read data registered at the address phase edge; unmapped reads 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (ap_ok && !hwrite) begin
            hrdata_r <= rd_word;
        end
    end

    // ========================================================================
    // event status, mask and interrupt line
    // ========================================================================
    assign rd_stat = ap_ok && !hwrite && ap_ofs == OFS_STATUS;

    always_comb begin
        status_set            = '0;
        status_set[ST_ACCEPT] = acc && !core_int_req_r;
        status_set[ST_TAKE]   = take_ok;
        status_set[ST_NMI]    = nmi_edge;
    end

    // read clears, but an event in the same cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= ST_RESET;
        end else begin
            status_r <= (rd_stat ? '0 : status_r) | status_set;
        end
    end

    // mask register, written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imask_r <= ST_RESET;
        end else if (ap_wr_r && ap_ofs_r == OFS_IMASK) begin
            imask_r <= hwdata[ST_W-1:0];
        end
    end

    // level output, one cycle behind the status bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & imask_r);
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    // helper copy of the fields so checks compare with what was arbitrated
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_q_r <= '0;
        end else begin
            prio_q_r <= prio_flat;
        end
    end

    property p_addr_x4;
        @(posedge hclk) disable iff (!hresetn)
        core_int_req_r |-> core_vec_addr_r == {22'h00_0000, core_vec_num_r, 2'b00};
    endproperty
    a_addr_x4: assert property (p_addr_x4) else $error("table address not 4x vector");

    property p_above_mask;
        @(posedge hclk) disable iff (!hresetn)
        core_int_req_r |-> core_level_r > {1'b0, $past(core_interrupt_mask)};
    endproperty
    a_above_mask: assert property (p_above_mask) else $error("accepted at or below mask");

    property p_lvl0_masked;
        @(posedge hclk) disable iff (!hresetn)
        core_int_req_r |-> core_level_r != 5'h00;
    endproperty
    a_lvl0_masked: assert property (p_lvl0_masked) else $error("level 0 accepted");

    property p_fixed_vec;
        @(posedge hclk) disable iff (!hresetn)
        core_int_req_r && core_vec_num_r < 8'h40 |->
            (core_vec_num_r == VEC_NMI && core_level_r == LVL_NMI) ||
            ((core_vec_num_r == VEC_BRK || core_vec_num_r == VEC_DBG) &&
             core_level_r == LVL_FIXED);
    endproperty
    a_fixed_vec: assert property (p_fixed_vec) else $error("bad fixed vector");

    property p_pin_field;
        @(posedge hclk) disable iff (!hresetn)
        $rose(core_int_req_r) && core_vec_num_r[7:3] == 5'h08 |->
            core_level_r[3:0] == prio_q_r[int'(core_vec_num_r[2:0])*4 +: 4];
    endproperty
    a_pin_field: assert property (p_pin_field) else $error("pin level mismatch");

    property p_reset_zero;
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> prio_flat == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("levels not 0 after reset");

    property p_write_field;
        @(posedge hclk) disable iff (!hresetn)
        prio_we |=> prio_flat[int'($past(ap_ofs_r[5:2]))*16 +: 4] == $past(hwdata[15:12]);
    endproperty
    a_write_field: assert property (p_write_field) else $error("field write lost");

    property p_tie_small;
        @(posedge hclk) disable iff (!hresetn)
        periph_req[4] && periph_req[5]      // two timer sources sharing one field
            |-> win_vec != SRC_VEC[13];
    endproperty
    a_tie_small: assert property (p_tie_small) else $error("tie not to smaller vector");

    property p_nmi_first;
        @(posedge hclk) disable iff (!hresetn)
        nmi_pend_r |=> core_int_req_r && core_vec_num_r == VEC_NMI;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi not ranked first");

    property p_present;
        @(posedge hclk) disable iff (!hresetn)
        acc |=> core_vec_num_r == $past(win_vec) && core_level_r == $past(win_lvl);
    endproperty
    a_present: assert property (p_present) else $error("winner not presented");

endmodule
`default_nettype wire

//--- src/ivpr_pkg.sv
// constants and source tables shared by the vector priority resolver
package ivpr_pkg;

    // ========================================================================
    // sizes
    // ========================================================================
    localparam int NREG = 10;              // priority registers
    localparam int NFLD = NREG * 4;        // 4-bit priority fields
    localparam int NPRG = 59;              // sources with a priority field
    localparam int NPIN = 8;               // external request pins
    localparam int NPER = NPRG - NPIN;     // peripheral request lines
    localparam int NSYN = NPIN + 1;        // pins plus the non-maskable pin

    // ========================================================================
    // register byte offsets (priority register k sits at 4*k)
    // ========================================================================
    localparam logic [7:0] OFS_PRIO0  = 8'h00;
    localparam logic [7:0] OFS_PRIO9  = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;  // sticky events, read clears
    localparam logic [7:0] OFS_IMASK  = 8'h2C;  // event mask
    localparam logic [7:0] OFS_CUR    = 8'h30;  // presented vector, read only

    // current-vector register layout
    localparam int CUR_VEC_LSB = 0;
    localparam int CUR_LVL_LSB = 8;
    localparam int CUR_REQ_BIT = 16;

    // status / mask bits
    localparam int ST_ACCEPT = 0;          // a new request went to the core
    localparam int ST_TAKE   = 1;          // the core took a vector
    localparam int ST_NMI    = 2;          // non-maskable edge seen
    localparam int ST_W      = 3;
    localparam logic [ST_W-1:0] ST_RESET = 3'h0;

    // ========================================================================
    // fixed sources
    // ========================================================================
    localparam logic [7:0] VEC_NMI   = 8'h0B;
    localparam logic [7:0] VEC_BRK   = 8'h0C;
    localparam logic [7:0] VEC_DBG   = 8'h0E;
    localparam logic [4:0] LVL_NMI   = 5'h10;  // above every field value
    localparam logic [4:0] LVL_FIXED = 5'h0F;  // break and debug
    localparam logic [15:0] PRIO_RESET = 16'h0000;

    // ========================================================================
    // programmable sources in ascending vector order; index order is the
    // fixed tie order, every vector appears once
    // ========================================================================
    localparam logic [7:0] SRC_VEC [NPRG] = '{
        8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
        8'h48, 8'h4C, 8'h50, 8'h54,
        8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C,
        8'h60, 8'h61, 8'h64, 8'h65, 8'h68, 8'h69, 8'h6C, 8'h6D,
        8'h70, 8'h71, 8'h72, 8'h73, 8'h74,
        8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C,
        8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
        8'h88, 8'h89, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C,
        8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF,
        8'hC0};

    // field number 4*reg + nibble, nibble 0 being the top four bits
    localparam logic [5:0] SRC_FLD [NPRG] = '{
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
        6'h08, 6'h09, 6'h0A, 6'h0B,
        6'h0C, 6'h0C, 6'h0C, 6'h0C, 6'h0D,
        6'h0E, 6'h0E, 6'h0F, 6'h0F, 6'h10, 6'h10, 6'h11, 6'h11,
        6'h12, 6'h12, 6'h12, 6'h12, 6'h13,
        6'h14, 6'h14, 6'h14, 6'h14, 6'h15,
        6'h16, 6'h16, 6'h16, 6'h16, 6'h17, 6'h17, 6'h17, 6'h17,
        6'h18, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D,
        6'h20, 6'h20, 6'h20, 6'h20, 6'h21, 6'h21, 6'h21, 6'h21,
        6'h26};

endpackage

//--- src/ivpr_prio_regs.sv
// storage for the ten priority registers, fields exported flat
`timescale 1ns/1ps
`default_nettype none
module ivpr_prio_regs
    import ivpr_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                wr_en,      // one-cycle write strobe
    input  wire logic [3:0]          wr_idx,     // register number
    input  wire logic [15:0]         wr_data,
    output logic      [NFLD*4-1:0]   prio_flat   // field f at [4f +: 4]
);
    // ========================================================================
    // one word per register, field f = 4k+n lands at nibble f of the bus
    // ========================================================================
    logic [15:0] word_r [NREG];                  // stored words

    for (genvar k = 0; k < NREG; k++) begin : g_reg
        // power-on level 0 masks every programmable source until software raises it
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                word_r[k] <= PRIO_RESET;
            end else if (wr_en && wr_idx == 4'(k)) begin
                word_r[k] <= wr_data;
            end
        end
        for (genvar n = 0; n < 4; n++) begin : g_nib
            // most significant nibble is field 0 of the register
            assign prio_flat[(4*k+n)*4 +: 4] = word_r[k][(3-n)*4 +: 4];
        end
    end
endmodule
`default_nettype wire

//--- src/ivpr_arbiter.sv
// combinational pick of the highest requesting source
`timescale 1ns/1ps
`default_nettype none
module ivpr_arbiter
    import ivpr_pkg::*;
(
    input  wire logic                nmi_req,
    input  wire logic                brk_req,
    input  wire logic                dbg_req,
    input  wire logic [NPRG-1:0]     prg_req,    // pins then peripherals
    input  wire logic [NFLD*4-1:0]   prio_flat,
    output logic                     win_found,
    output logic      [7:0]          win_vec,
    output logic      [4:0]          win_lvl
);
    // ========================================================================
    // scan from the largest vector down with >=, so at equal level the
    // smaller vector wins; level 0 never competes
    // ========================================================================
    always_comb begin
        logic [4:0] lvl;
        lvl     = '0;
        win_vec = '0;
        win_lvl = '0;
        for (int i = NPRG - 1; i >= 0; i--) begin
            lvl = {1'b0, prio_flat[int'(SRC_FLD[i])*4 +: 4]};
            // level 0 stays out
            if (prg_req[i] && lvl != 5'h00 && lvl >= win_lvl) begin
                win_vec = SRC_VEC[i];
                win_lvl = lvl;
            end
        end
        // fixed sources rank ahead of any field at the same level
        if (dbg_req && LVL_FIXED >= win_lvl) begin
            win_vec = VEC_DBG;
            win_lvl = LVL_FIXED;
        end
        if (brk_req && LVL_FIXED >= win_lvl) begin
            win_vec = VEC_BRK;
            win_lvl = LVL_FIXED;
        end
        if (nmi_req) begin
            win_vec = VEC_NMI;
            win_lvl = LVL_NMI;
        end
        win_found = (win_lvl != 5'h00);
    end
endmodule
`default_nettype wire

//--- tb/ivpr_core_model.sv
// behavioural core that takes presented vectors and reads the table entry
`timescale 1ns/1ps
`default_nettype none
module ivpr_core_model (
    input  wire logic        hclk,
    input  wire logic        take_en,       // bench lets the core accept
    input  wire logic        core_int_req,
    input  wire logic [31:0] core_vec_addr,
    output logic             core_take,
    output logic [31:0]      fetch_addr     // entry read for the handler
);
    // take a cycle after the request is seen; one pulse, never twice in a row
    always_ff @(posedge hclk) begin
        core_take <= take_en && core_int_req && !core_take;
        if (core_take) begin
            fetch_addr <= core_vec_addr;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the vector priority resolver
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ivpr_pkg::*;
    logic            hclk, hresetn, hsel, hwrite, hrdy, hresp, nmi, brk, dbg, take_en;
    logic [31:0]     haddr, hwdata, hrdata, vaddr, fetch, rd;
    logic [1:0]      htrans;
    logic [NPIN-1:0] pins;
    logic [NPER-1:0] preq;
    logic [3:0]      cmask;
    logic            take, ireq, irq;
    logic [7:0]      vec;
    logic [4:0]      lvl;
    int              miscompares, comparisons, i;
    // ========================================================================
    // clock, design and core
    // ========================================================================
    initial begin
        hclk = 0;
        forever #2.5 hclk = ~hclk;
    end
    ivpr_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .ext_request_pin(pins),
        .nmi_pin(nmi), .break_req(brk), .debug_interface_request(dbg),
        .periph_req(preq), .core_interrupt_mask(cmask), .core_take(take),
        .core_int_req(ireq), .core_vec_num(vec), .core_vec_addr(vaddr),
        .core_level(lvl), .irq(irq));
    ivpr_core_model u_core (.hclk(hclk), .take_en(take_en), .core_int_req(ireq),
        .core_vec_addr(vaddr), .core_take(take), .fetch_addr(fetch));
    // ========================================================================
    // tasks
    // ========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one word transfer; address held until ready, data until ready again
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        if (hrdy !== 1'b1) n = 100;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hrdy !== 1'b1 && n < 100);
        rd = hrdata;
        chk({31'h0, hresp}, 0);
        if (n >= 100 || hrdy !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask
    // bounded wait for a presented vector, then its address and level
    task automatic want(input logic [7:0] v, input logic [4:0] l);
        for (int n = 0; n < 30 && !(ireq === 1'b1 && vec === v); n++) @(negedge hclk);
        chk({24'h0, vec}, {24'h0, v});
        chk(vaddr, {22'h0, v, 2'h0});
        chk({27'h0, lvl}, {27'h0, l});
    endtask
    // ========================================================================
    // sequence
    // ========================================================================
    initial begin
        {hresetn, hwrite, nmi, brk, dbg, take_en, htrans, haddr, hwdata} = '0;
        {pins, preq, cmask, miscompares, comparisons} = '0;
        hsel = 1;
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        for (i = 0; i < NREG; i++) begin
            bus(0, 8'(4 * i), 0);
            chk(rd, 0);
        end
        bus(1, OFS_PRIO0, 32'h0000_1234);
        bus(0, OFS_PRIO0, 0);
        chk(rd, 32'h0000_1234);
        bus(0, 8'h40, 0);
        chk(rd, 0);
        bus(1, OFS_IMASK, 1);
        bus(1, 8'h08, 32'h0000_7000);
        bus(1, 8'h0C, 32'h0000_7000);
        cmask <= 4'h6;
        preq <= 51'h31;
        want(8'h48, 5'h07);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 1);
        bus(0, OFS_STATUS, 0);
        chk(rd, 1);
        repeat (3) @(negedge hclk);
        chk({31'h0, irq}, 0);
        @(posedge hclk);
        preq <= 51'h30;
        want(8'h58, 5'h07);
        bus(0, OFS_CUR, 0);
        chk(rd, 32'h0001_0758);
        cmask <= 4'h7;
        repeat (3) @(negedge hclk);
        chk({31'h0, ireq}, 0);
        @(posedge hclk);
        cmask <= 4'h0;
        bus(1, 8'h0C, 0);
        bus(1, 8'h08, 0);
        repeat (3) @(negedge hclk);
        chk({31'h0, ireq}, 0);
        @(posedge hclk);
        pins <= 8'h08;
        want(8'h43, 5'h04);
        @(posedge hclk);
        pins <= 0;
        take_en <= 1;
        brk <= 1;
        dbg <= 1;
        @(posedge hclk);
        brk <= 0;
        dbg <= 0;
        want(VEC_BRK, 5'h0F);
        repeat (3) @(negedge hclk);
        chk(fetch, 32'h0000_0030);
        want(VEC_DBG, 5'h0F);
        repeat (2) @(negedge hclk);
        chk(fetch, 32'h0000_0038);
        @(posedge hclk);
        nmi <= 1;
        want(VEC_NMI, 5'h10);
        repeat (3) @(negedge hclk);
        chk(fetch, 32'h0000_002C);
        complete_run();
    end
endmodule
`default_nettype wire
